/* File: hdl/uad_regs.svh */
// register offsets, field positions, reset values and timing of the accessory detector link
`ifndef UAD_REGS_SVH
`define UAD_REGS_SVH
// device slave address on the serial bus; arbitrary value
`define UAD_I2C_ADDR 7'h25
// device register offsets
`define UAD_REG_CTRL 8'h02
`define UAD_REG_IRQ 8'h03
`define UAD_REG_IDCODE 8'h07
`define UAD_REG_DTYPE1 8'h0A
`define UAD_REG_DTYPE2 8'h0B
`define UAD_REG_MAN1 8'h13
`define UAD_REG_MAN2 8'h14
`define UAD_REG_RESET 8'h1B
// device fields and reset values
`define UAD_CTRL_DET_EN 0
`define UAD_CTRL_MANUAL 1
`define UAD_CTRL_RST 8'h01
`define UAD_IRQ_ATTACH 0
`define UAD_IRQ_DETACH 1
`define UAD_RESET_BIT 0
`define UAD_DT1_CHARGER 0
`define UAD_DT1_USB_PORT 1
`define UAD_DT2_USB_OFF 0
`define UAD_DT2_USB_ON 1
`define UAD_DT2_UART_OFF 2
`define UAD_DT2_UART_ON 3
`define UAD_DT2_UNKNOWN 4
`define UAD_MAN2_STARTUP 0
`define UAD_MAN2_FIXTURE 1
// identification codes of the connector resistance
`define UAD_ID_OPEN 5'h1F
`define UAD_ID_CHG 5'h17
`define UAD_ID_442K 5'h1B
`define UAD_ID_USB_OFF 5'h18
`define UAD_ID_USB_ON 5'h19
`define UAD_ID_UART_OFF 5'h1C
`define UAD_ID_UART_ON 5'h1D
// switch path codes, bit 0 primary pair, bit 1 secondary pair
`define UAD_PATH_OPEN 2'h0
`define UAD_PATH_PRIMARY 2'h1
`define UAD_PATH_SECONDARY 2'h2
// controller registers on the processor bus
`define UAD_HREG_CMD 8'h00
`define UAD_HREG_WDATA 8'h04
`define UAD_HREG_STATUS 8'h08
`define UAD_HREG_RDATA 8'h0C
`define UAD_CMD_READ 8
`define UAD_STAT_BUSY 0
`define UAD_STAT_NACK 1
`define UAD_STAT_ALERT 2
// timing
`define UAD_CLK_KHZ 100000
`define UAD_SCL_KHZ 400
`define UAD_QTR_CYC ((`UAD_CLK_KHZ + 4 * `UAD_SCL_KHZ - 1) / (4 * `UAD_SCL_KHZ))
`endif

/* File: hdl/uad_pkg.sv */
// state types of the accessory detector and of its bus controller
package uad_pkg;
   typedef enum logic [6:0] {
      SL_IDLE = 7'h01, SL_ADDR = 7'h02, SL_ACK_A = 7'h04, SL_WR = 7'h08,
      SL_ACK_W = 7'h10, SL_RD = 7'h20, SL_ACK_R = 7'h40
   } uad_slv_st_t;
   typedef enum logic [3:0] {
      HM_IDLE = 4'h1, HM_START = 4'h2, HM_BIT = 4'h4, HM_STOP = 4'h8
   } uad_mst_st_t;
   typedef struct packed {
      logic [2:0] scl;
      logic [2:0] sda;
      logic [2:0] bat;
      logic [1:0] io;
      logic [1:0] vbus;
      logic [4:0] id0;
      logic [4:0] id1;
   } uad_sync_t;
   typedef struct packed {
      uad_slv_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rd;
      logic first;
      logic oe;
   } uad_bus_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] irq;
      logic [7:0] dt1;
      logic [7:0] dt2;
      logic [7:0] man1;
      logic [7:0] man2;
      logic [4:0] id_code;
      logic attached;
      logic [1:0] path;
      logic startup;
      logic fixture;
      logic alert_low;
   } uad_core_t;
   typedef struct packed {
      uad_sync_t sy;
      uad_bus_t bus;
      uad_core_t c;
   } uad_dev_st_t;
   typedef struct packed {
      logic [1:0] alert;
      logic [1:0] sda;
      uad_mst_st_t st;
      logic [6:0] qcnt;
      logic [1:0] q;
      logic [3:0] bitn;
      logic [1:0] byten;
      logic frame_b;
      logic rd;
      logic [7:0] reg_a;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [7:0] sh;
      logic nack;
      logic scl;
      logic sda_oe;
      logic ack;
      logic [31:0] dat;
   } uad_host_st_t;
endpackage : uad_pkg

/* File: hdl/uad_link_if.sv */
// serial link between the accessory detector and its bus controller
`timescale 1ns/1ns
interface uad_link_if;
   logic scl;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;
   logic alert_low;
   // open-drain data line with pull-up
   assign sda = !(sda_host_oe && !sda_host_o) && !(sda_dev_oe && !sda_dev_o);
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe, output alert_low);
   modport host (output scl, input sda, output sda_host_o, output sda_host_oe,
      input alert_low);
endinterface : uad_link_if

/* File: hdl/uad_device.sv */
// accessory detector with serial register slave and data path switch control
// Operation
// - detect on battery; bus, alert need io
// - reset loads defaults, opens all paths
// - after reset wait watching supply, id
// - battery rising edge causes power-on reset
// - reset bit at 0x1B resets device
// - fast-mode serial slave, up to 400 kHz
// - id resistance encoded as five-bit code
// - unknown codes still alert; open reads 1F
// - charger codes detected only with supply
// - factory codes route switches automatically
// - factory change reroutes without detach
// - uart factory secondary, usb factory primary
// - startup high in startup-on factory modes
// - fixture flag asserted in any factory mode
// - update status and assert alert in the same cycle
// - processor controls detection and switches
// - automatic or manual switch selection
// - alert active low on status change
// - processor reads 0x03 then type registers
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "uad_regs.svh"
module uad_device import uad_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic battery_valid_i,
   input wire logic io_supply_i,
   input wire logic bus_supply_sense_i,
   input wire logic [4:0] ident_code_i,
   uad_link_if.dev link,
   output logic route_primary_o,
   output logic route_secondary_o,
   output logic startup_sel_o,
   output logic fixture_flag_o,
   output logic fixture_pull_low_oe_o
);
   localparam uad_bus_t BUS_RST = '{st: SL_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
      rd: 1'b0, first: 1'b0, oe: 1'b0};
   localparam uad_core_t CORE_RST = '{ctrl: `UAD_CTRL_RST, irq: 8'h00, dt1: 8'h00,
      dt2: 8'h00, man1: 8'h00, man2: 8'h00, id_code: `UAD_ID_OPEN, attached: 1'b0,
      path: `UAD_PATH_OPEN, startup: 1'b0, fixture: 1'b0, alert_low: 1'b1};
   localparam uad_dev_st_t ST_RST = '{sy: '{scl: 3'h7, sda: 3'h7, bat: 3'h0, io: 2'h0,
      vbus: 2'h0, id0: `UAD_ID_OPEN, id1: `UAD_ID_OPEN}, bus: BUS_RST, c: CORE_RST};

   uad_dev_st_t s;
   uad_dev_st_t nxt;

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      uad_dev_st_t n;
      logic sr, sf, start, stop, io_ok, bat_ok, load, wr_en, vb, is_chg, present;
      logic irq_clr, fact;
      logic [7:0] wa, v, set;
      logic [4:0] id;
      n = s;
      load = 1'b0;
      wr_en = 1'b0;
      irq_clr = 1'b0;
      v = 8'h00;
      set = 8'h00;
      wa = s.bus.ptr;
      fact = 1'b0;
      // pin synchronisers; levels are taken from the second stage, edges from the second and third
      n.sy.scl = {s.sy.scl[1:0], link.scl};
      n.sy.sda = {s.sy.sda[1:0], link.sda};
      n.sy.bat = {s.sy.bat[1:0], battery_valid_i};
      n.sy.io = {s.sy.io[0], io_supply_i};
      n.sy.vbus = {s.sy.vbus[0], bus_supply_sense_i};
      n.sy.id0 = ident_code_i;
      n.sy.id1 = s.sy.id0;
      sr = s.sy.scl[1] & ~s.sy.scl[2];
      sf = ~s.sy.scl[1] & s.sy.scl[2];
      start = s.sy.scl[1] & s.sy.scl[2] & ~s.sy.sda[1] & s.sy.sda[2];
      stop = s.sy.scl[1] & s.sy.scl[2] & s.sy.sda[1] & ~s.sy.sda[2];
      io_ok = s.sy.io[1];
      bat_ok = s.sy.bat[1];
      vb = s.sy.vbus[1];
      id = s.sy.id1;
      // ***********************************************
      // serial slave
      // ***********************************************
      if (!io_ok) begin
         n.bus.st = SL_IDLE;
         n.bus.oe = 1'b0;
      end else if (start) begin
         n.bus.st = SL_ADDR;
         n.bus.cnt = 4'h0;
         n.bus.oe = 1'b0;
      end else if (stop) begin
         n.bus.st = SL_IDLE;
         n.bus.oe = 1'b0;
      end else begin
         unique case (s.bus.st)
            SL_IDLE: ;
            SL_ADDR, SL_WR: begin
               if (sr && s.bus.cnt != 4'h8) begin
                  n.bus.sh = {s.bus.sh[6:0], s.sy.sda[1]};
                  n.bus.cnt = s.bus.cnt + 4'h1;
               end else if (sf && s.bus.cnt == 4'h8) begin
                  if (s.bus.st == SL_ADDR) begin
                     if (s.bus.sh[7:1] == `UAD_I2C_ADDR) begin
                        n.bus.oe = 1'b1;
                        n.bus.rd = s.bus.sh[0];
                        n.bus.first = 1'b1;
                        n.bus.st = SL_ACK_A;
                     end else begin
                        n.bus.st = SL_IDLE;
                     end
                  end else begin
                     // first data byte after the address sets the register pointer
                     if (s.bus.first) begin
                        n.bus.ptr = s.bus.sh;
                        n.bus.first = 1'b0;
                     end else begin
                        wr_en = 1'b1;
                        n.bus.ptr = s.bus.ptr + 8'h01;
                     end
                     n.bus.oe = 1'b1;
                     n.bus.st = SL_ACK_W;
                  end
               end
            end
            SL_ACK_A: begin
               if (sf) begin
                  n.bus.oe = 1'b0;
                  n.bus.cnt = 4'h0;
                  n.bus.st = SL_WR;
                  load = s.bus.rd;
               end
            end
            SL_ACK_W: begin
               if (sf) begin
                  n.bus.oe = 1'b0;
                  n.bus.cnt = 4'h0;
                  n.bus.st = SL_WR;
               end
            end
            SL_RD: begin
               if (sf) begin
                  if (s.bus.cnt == 4'h8) begin
                     n.bus.oe = 1'b0;
                     n.bus.st = SL_ACK_R;
                  end else begin
                     n.bus.oe = ~s.bus.sh[7];
                     n.bus.sh = {s.bus.sh[6:0], 1'b0};
                     n.bus.cnt = s.bus.cnt + 4'h1;
                  end
               end
            end
            SL_ACK_R: begin
               // first doubles as the not-acknowledged flag here
               if (sr) begin
                  n.bus.first = s.sy.sda[1];
               end else if (sf) begin
                  if (s.bus.first) begin
                     n.bus.st = SL_IDLE;
                  end else begin
                     load = 1'b1;
                  end
               end
            end
         endcase
      end
      if (load) begin
         case (s.bus.ptr)
            `UAD_REG_CTRL: v = s.c.ctrl;
            `UAD_REG_IRQ: v = s.c.irq;
            `UAD_REG_IDCODE: v = {3'b000, s.c.id_code};
            `UAD_REG_DTYPE1: v = s.c.dt1;
            `UAD_REG_DTYPE2: v = s.c.dt2;
            `UAD_REG_MAN1: v = s.c.man1;
            `UAD_REG_MAN2: v = s.c.man2;
            default: v = 8'h00;
         endcase
         irq_clr = (s.bus.ptr == `UAD_REG_IRQ);
         n.bus.sh = {v[6:0], 1'b0};
         n.bus.oe = ~v[7];
         n.bus.cnt = 4'h1;
         n.bus.st = SL_RD;
         n.bus.ptr = s.bus.ptr + 8'h01;
      end
      // ***********************************************
      // registers written by the processor
      // ***********************************************
      if (wr_en) begin
         unique case (wa)
            `UAD_REG_CTRL: n.c.ctrl = s.bus.sh;
            `UAD_REG_MAN1: n.c.man1 = s.bus.sh;
            `UAD_REG_MAN2: n.c.man2 = s.bus.sh;
            default: ;
         endcase
      end
      // ***********************************************
      // accessory detection
      // ***********************************************
      is_chg = (id == `UAD_ID_CHG) || (id == `UAD_ID_442K);
      present = vb || (id != `UAD_ID_OPEN && !(is_chg && !vb));
      if (bat_ok && s.c.ctrl[`UAD_CTRL_DET_EN]) begin
         if (present && (!s.c.attached || id != s.c.id_code)) begin
            set[`UAD_IRQ_ATTACH] = 1'b1;
            n.c.attached = 1'b1;
            n.c.id_code = id;
            n.c.dt1 = 8'h00;
            n.c.dt2 = 8'h00;
            n.c.dt1[`UAD_DT1_CHARGER] = (id == `UAD_ID_CHG) && vb;
            n.c.dt1[`UAD_DT1_USB_PORT] = (id == `UAD_ID_OPEN) && vb;
            n.c.dt2[`UAD_DT2_USB_OFF] = (id == `UAD_ID_USB_OFF);
            n.c.dt2[`UAD_DT2_USB_ON] = (id == `UAD_ID_USB_ON);
            n.c.dt2[`UAD_DT2_UART_OFF] = (id == `UAD_ID_UART_OFF);
            n.c.dt2[`UAD_DT2_UART_ON] = (id == `UAD_ID_UART_ON);
            fact = (id == `UAD_ID_USB_OFF) || (id == `UAD_ID_USB_ON) ||
               (id == `UAD_ID_UART_OFF) || (id == `UAD_ID_UART_ON);
            n.c.dt2[`UAD_DT2_UNKNOWN] = !fact && id != `UAD_ID_OPEN && id != `UAD_ID_CHG;
         end else if (!present && s.c.attached) begin
            set[`UAD_IRQ_DETACH] = 1'b1;
            n.c.attached = 1'b0;
            n.c.id_code = `UAD_ID_OPEN;
            n.c.dt1 = 8'h00;
            n.c.dt2 = 8'h00;
         end
      end
      // a new event in the cycle of the clearing read survives
      n.c.irq = (irq_clr ? 8'h00 : s.c.irq) | set;
      // ***********************************************
      // switch and factory outputs
      // ***********************************************
      if (n.c.ctrl[`UAD_CTRL_MANUAL]) begin
         n.c.path = (n.c.man1[1:0] == 2'b11) ? `UAD_PATH_OPEN : n.c.man1[1:0];
         n.c.startup = n.c.man2[`UAD_MAN2_STARTUP];
         n.c.fixture = n.c.man2[`UAD_MAN2_FIXTURE];
      end else begin
         n.c.path = `UAD_PATH_OPEN;
         if (n.c.dt2[`UAD_DT2_UART_OFF] || n.c.dt2[`UAD_DT2_UART_ON]) begin
            n.c.path = `UAD_PATH_SECONDARY;
         end else if (n.c.dt2[`UAD_DT2_USB_OFF] || n.c.dt2[`UAD_DT2_USB_ON] ||
               n.c.dt1[`UAD_DT1_USB_PORT]) begin
            n.c.path = `UAD_PATH_PRIMARY;
         end
         n.c.startup = n.c.dt2[`UAD_DT2_USB_ON] | n.c.dt2[`UAD_DT2_UART_ON];
         n.c.fixture = |n.c.dt2[`UAD_DT2_UART_ON:`UAD_DT2_USB_OFF];
      end
      n.c.alert_low = ~((|n.c.irq) & io_ok);
      if (wr_en && wa == `UAD_REG_RESET && s.bus.sh[`UAD_RESET_BIT]) begin
         n.c = CORE_RST;
      end
      if (s.sy.bat[1] & ~s.sy.bat[2]) begin
         n.c = CORE_RST;
         n.bus = BUS_RST;
      end
      nxt = n;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= ST_RST;
      end else begin
         s <= nxt;
      end
   end

   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = s.bus.oe;
   assign link.alert_low = s.c.alert_low;
   assign route_primary_o = s.c.path[0];
   assign route_secondary_o = s.c.path[1];
   assign startup_sel_o = s.c.startup;
   assign fixture_flag_o = s.c.fixture;
   assign fixture_pull_low_oe_o = s.c.fixture;
endmodule : uad_device

/* File: hdl/uad_host.sv */
// processor-side serial bus controller, ordered over classic wishbone
`timescale 1ns/1ns
`include "uad_regs.svh"
module uad_host import uad_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   uad_link_if.host link
);
   localparam logic [6:0] QTR_LAST = 7'(`UAD_QTR_CYC - 1);

   uad_host_st_t s;
   uad_host_st_t nxt;

   // a read's first frame only sets the pointer; in its second frame the data byte is released
   function automatic logic [7:0] byte_of(input logic fb, input logic [1:0] idx,
         input logic [7:0] ra, input logic [7:0] wd);
      logic [7:0] b;
      b = 8'hFF;
      if (idx == 2'd0) begin
         b = {`UAD_I2C_ADDR, fb};
      end else if (!fb && idx == 2'd1) begin
         b = ra;
      end else if (!fb) begin
         b = wd;
      end
      return b;
   endfunction : byte_of

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      uad_host_st_t n;
      logic tick, reading;
      logic [1:0] last;
      n = s;
      n.ack = 1'b0;
      n.alert = {s.alert[0], link.alert_low};
      n.sda = {s.sda[0], link.sda};
      tick = (s.qcnt == QTR_LAST);
      reading = s.frame_b && s.byten == 2'd1;
      last = (s.frame_b || s.rd) ? 2'd1 : 2'd2;
      n.qcnt = (tick || s.st == HM_IDLE) ? 7'h00 : s.qcnt + 7'h01;
      if (tick) begin
         n.q = s.q + 2'd1;
         unique case (s.st)
            HM_IDLE: begin
            end
            HM_START: begin
               unique case (s.q)
                  2'd0: begin
                     n.sda_oe = 1'b0;
                     n.scl = 1'b1;
                  end
                  2'd1: n.sda_oe = 1'b1;
                  2'd2: n.scl = 1'b0;
                  2'd3: begin
                     n.st = HM_BIT;
                     n.bitn = 4'h0;
                     n.byten = 2'd0;
                     n.sh = byte_of(s.frame_b, 2'd0, s.reg_a, s.wdata);
                  end
               endcase
            end
            HM_BIT: begin
               unique case (s.q)
                  2'd0: n.sda_oe = (s.bitn != 4'h8 && !reading) ? ~s.sh[7] : 1'b0;
                  2'd1: n.scl = 1'b1;
                  2'd2: begin
                     if (s.bitn != 4'h8) begin
                        n.sh = {s.sh[6:0], s.sda[1]};
                     end else if (reading) begin
                        n.rdata = s.sh;
                     end else begin
                        n.nack = s.sda[1];
                     end
                  end
                  2'd3: begin
                     n.scl = 1'b0;
                     if (s.bitn != 4'h8) begin
                        n.bitn = s.bitn + 4'h1;
                     end else if (s.nack || s.byten == last) begin
                        n.st = HM_STOP;
                     end else begin
                        n.bitn = 4'h0;
                        n.byten = s.byten + 2'd1;
                        n.sh = byte_of(s.frame_b, s.byten + 2'd1, s.reg_a, s.wdata);
                     end
                  end
               endcase
            end
            HM_STOP: begin
               unique case (s.q)
                  2'd0: n.sda_oe = 1'b1;
                  2'd1: n.scl = 1'b1;
                  2'd2: n.sda_oe = 1'b0;
                  2'd3: begin
                     if (!s.frame_b && s.rd && !s.nack) begin
                        n.frame_b = 1'b1;
                        n.st = HM_START;
                     end else begin
                        n.st = HM_IDLE;
                     end
                  end
               endcase
            end
         endcase
      end

      // ***********************************************
      // wishbone slave
      // ***********************************************
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         n.ack = 1'b1;
         n.dat = 32'h0000_0000;
         if (wb_we_i) begin
            // a command while busy is dropped
            if (wb_adr_i == `UAD_HREG_CMD && wb_sel_i[0] && s.st == HM_IDLE) begin
               n.reg_a = wb_dat_i[7:0];
               n.rd = wb_dat_i[`UAD_CMD_READ];
               n.nack = 1'b0;
               n.frame_b = 1'b0;
               n.st = HM_START;
               n.q = 2'd0;
               n.qcnt = 7'h00;
            end
            if (wb_adr_i == `UAD_HREG_WDATA && wb_sel_i[0]) begin
               n.wdata = wb_dat_i[7:0];
            end
         end else begin
            case (wb_adr_i)
               `UAD_HREG_CMD: n.dat = {23'h0, s.rd, s.reg_a};
               `UAD_HREG_WDATA: n.dat = {24'h0, s.wdata};
               `UAD_HREG_STATUS: begin
                  n.dat[`UAD_STAT_BUSY] = (s.st != HM_IDLE);
                  n.dat[`UAD_STAT_NACK] = s.nack;
                  n.dat[`UAD_STAT_ALERT] = ~s.alert[1];
               end
               `UAD_HREG_RDATA: n.dat = {24'h0, s.rdata};
               default: n.dat = 32'h0000_0000;
            endcase
         end
      end
      nxt = n;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '{alert: 2'b11, sda: 2'b11, st: HM_IDLE, qcnt: 7'h00, q: 2'd0, bitn: 4'h0,
            byten: 2'd0, frame_b: 1'b0, rd: 1'b0, reg_a: 8'h00, wdata: 8'h00,
            rdata: 8'h00, sh: 8'h00, nack: 1'b0, scl: 1'b1, sda_oe: 1'b0, ack: 1'b0,
            dat: 32'h0000_0000};
      end else begin
         s <= nxt;
      end
   end

   assign wb_dat_o = s.dat;
   assign wb_ack_o = s.ack;
   assign link.scl = s.scl;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = s.sda_oe;
endmodule : uad_host

/* File: testbench/uad_sva.sv */
// concurrent checks on the serial link between bus controller and detector
`timescale 1ns/1ns
module uad_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic alert_low
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic in_frame_ff;
   logic sda_ff;
   // frame tracker: start and stop are data edges while the clock is high
   always_ff @(posedge clk_i) begin
      sda_ff <= sda;
      if (rst_i)
         in_frame_ff <= 1'b0;
      else if (scl && sda_ff && !sda)
         in_frame_ff <= 1'b1;
      else if (scl && !sda_ff && sda)
         in_frame_ff <= 1'b0;
   end
   property p_rst_alert; $fell(rst_i) |-> alert_low; endproperty
   a_rst_alert: assert property (p_rst_alert) else $error("alert not idle after reset");
   property p_rst_sda; $fell(rst_i) |-> !sda_dev_oe; endproperty
   a_rst_sda: assert property (p_rst_sda) else $error("data held after reset");
   property p_rst_host; $fell(rst_i) |-> scl && !sda_host_oe; endproperty
   a_rst_host: assert property (p_rst_host) else $error("host link not idle");
   property p_dev_chg; $changed(sda_dev_oe) |-> !scl; endproperty
   a_dev_chg: assert property (p_dev_chg) else $error("data moved with clock high");
   property p_scl_hi; $rose(scl) |-> scl [*8]; endproperty
   a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
   property p_scl_lo; $fell(scl) |-> !scl [*8]; endproperty
   a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
   property p_dev_frame; sda_dev_oe |-> in_frame_ff; endproperty
   a_dev_frame: assert property (p_dev_frame) else $error("device drove outside frame");
   // the tail after a stop covers the slave's synchroniser delay
   property p_alert_hold;
      !alert_low && !in_frame_ff && !$past(in_frame_ff, 8) |=> !alert_low || in_frame_ff;
   endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert left without read");
endmodule : uad_sva

/* File: testbench/usb_accessory_detect_switch_tb_top.sv */
// self-checking bench joining the bus controller and the accessory detector
`timescale 1ns/1ns
`include "uad_regs.svh"
module usb_accessory_detect_switch_tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, bat = 1'b1, io = 1'b1, vbus = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [4:0] ident = 5'h1F, c;
   wire [4:0] outs;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q, seed = 32'h13;
   logic [9:0] e;
   logic [4:0] fac [4] = '{5'h18, 5'h19, 5'h1C, 5'h1D};
   logic [4:0] unk [4] = '{5'h15, 5'h16, 5'h1A, 5'h1E};
   int bad_count = 0, n_checks = 0;
   uad_link_if link();
   uad_host uad_host_inst(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .link(link));
   uad_device uad_device_inst(.clk_i(clk_i), .rst_i(rst_i), .battery_valid_i(bat),
      .io_supply_i(io), .bus_supply_sense_i(vbus), .ident_code_i(ident), .link(link),
      .route_primary_o(outs[4]), .route_secondary_o(outs[3]), .startup_sel_o(outs[2]),
      .fixture_flag_o(outs[1]), .fixture_pull_low_oe_o(outs[0]));
   uad_sva uad_sva_inst(.clk_i(clk_i), .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
      .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
      .alert_low(link.alert_low));
   initial forever #5 clk_i = ~clk_i;
   // ******************
   // helpers
   // ******************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction : xs
   // {type2 bits, primary, secondary, startup, fixture, pull-low} for a code
   function automatic logic [9:0] ex(input logic [4:0] k);
      case (k)
         `UAD_ID_USB_OFF: ex = 10'h033;
         `UAD_ID_USB_ON: ex = 10'h057;
         `UAD_ID_UART_OFF: ex = 10'h08B;
         `UAD_ID_UART_ON: ex = 10'h10F;
         default: ex = 10'h200;
      endcase
   endfunction : ex
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // one device register access over the link; a read leaves the byte in q
   task automatic acc(input logic r, input logic [7:0] ra, input logic [7:0] wd);
      wb(1'b1, `UAD_HREG_WDATA, {24'h0, wd});
      wb(1'b1, `UAD_HREG_CMD, {23'h0, r, ra});
      do wb(1'b0, `UAD_HREG_STATUS, 32'h0); while (q[`UAD_STAT_BUSY] !== 1'b0);
      chk(q[`UAD_STAT_NACK], 1'b0);
      if (r)
         wb(1'b0, `UAD_HREG_RDATA, 32'h0);
   endtask : acc
   task automatic wait_alert;
      do @(posedge clk_i); while (link.alert_low !== 1'b0);
   endtask : wait_alert
   task automatic step(input logic [4:0] k, input logic [7:0] ev);
      @(posedge clk_i);
      ident <= k;
      wait_alert();
      acc(1'b1, `UAD_REG_IRQ, 8'h00);
      chk(q[7:0], ev);
      chk(link.alert_low, 1'b1);
      e = ex(k);
      chk(outs, e[4:0]);
   endtask : step
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   // ******************
   // scenarios
   // ******************
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      chk({link.alert_low, outs}, 6'h20);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      for (int i = 0; i < 2; i++) begin
         do begin
            seed = xs(seed);
            c = fac[seed[1:0]];
         end while (c === ident);
         step(c, 8'h01);
      end
      seed = xs(seed);
      step(unk[seed[1:0]], 8'h01);
      acc(1'b1, `UAD_REG_DTYPE2, 8'h00);
      chk(q[4:0], e[9:5]);
      step(5'h1F, 8'h02);
      @(posedge clk_i);
      ident <= `UAD_ID_CHG;
      repeat (200) @(posedge clk_i);
      chk(link.alert_low, 1'b1);
      io <= 1'b0;
      vbus <= 1'b1;
      repeat (200) @(posedge clk_i);
      chk(link.alert_low, 1'b1);
      io <= 1'b1;
      wait_alert();
      acc(1'b1, `UAD_REG_IRQ, 8'h00);
      chk(q[7:0], 8'h01);
      // a fresh battery edge wipes the attach, so the charger raises the alert again
      bat <= 1'b0;
      repeat (5) @(posedge clk_i);
      bat <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(link.alert_low, 1'b0);
      acc(1'b1, `UAD_REG_DTYPE1, 8'h00);
      chk(q[7:0], 8'h01);
      acc(1'b0, `UAD_REG_CTRL, 8'h03);
      acc(1'b0, `UAD_REG_MAN1, 8'h02);
      chk(outs, 5'h08);
      acc(1'b0, `UAD_REG_RESET, 8'h01);
      chk(outs, 5'h00);
      acc(1'b1, `UAD_REG_CTRL, 8'h00);
      chk(q[7:0], `UAD_CTRL_RST);
      complete_run();
   end
   initial begin
      // the tests need some 103k cycles, nearly all of it serial frames
      #1250000;
      bad_count++;
      $display("Error %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : usb_accessory_detect_switch_tb_top
